// file: rtl/msa_params.svh
`ifndef MSA_PARAMS_SVH
`define MSA_PARAMS_SVH

// Register offsets on the register port.
`define MSA_OFS_TEMP_SLOT   12'h00f
`define MSA_OFS_AUX_CFG     12'h010
`define MSA_OFS_SYSTEM_CLOCK_KHZ     12'h012
`define MSA_OFS_LINE_CYCLES 12'h014
`define MSA_OFS_NS_LOW      12'h016
`define MSA_OFS_NS_HIGH     12'h018

// Temperature slot fields.
`define MSA_TEMP_MUX_HI     7
`define MSA_TEMP_MUX_LO     4
`define MSA_TEMP_DIS_BIT    3
`define MSA_TEMP_GAIN_HI    2
`define MSA_TEMP_GAIN_LO    0
`define MSA_TEMP_RESET      8'h8a
`define MSA_GAIN_MAX_CODE   3'h5
`define MSA_MUX_LAST_PAIR   4'h6
`define MSA_MUX_AUTOZERO    4'h7
`define MSA_MUX_V_LAST      4'h2
`define MSA_MUX_I_LAST      4'h5

// Auxiliary configuration fields.
`define MSA_AUX_EN_BIT      6
`define MSA_AUX_SEL_HI      2
`define MSA_AUX_SEL_LO      0
`define MSA_AUX_WRITE_MASK  16'h0047
`define MSA_AUX_RESET       16'h0000

// Reset values of the timing registers, and the frame unit.
`define MSA_SYSTEM_CLOCK_KHZ_RESET   16'h1f40
`define MSA_LINE_CYC_RESET  16'h0010
`define MSA_NS_RESET        32'h00010000
`define MSA_FRAME_UNIT      32'h00010000

`endif

// file: rtl/msa_pkg.sv
`default_nettype none
package msa_pkg;
  typedef enum logic [2:0] {
    MSA_SRC_VOLTAGE,
    MSA_SRC_CURRENT,
    MSA_SRC_NEUTRAL,
    MSA_SRC_AUTOZERO,
    MSA_SRC_TEMPERATURE
  } msa_source_type;

  typedef enum logic [1:0] {
    MSA_RMS_COLLECT,
    MSA_RMS_ROOT
  } msa_rms_state_type;
endpackage
`default_nettype wire

// file: rtl/msa_dsp_timer.sv
`default_nettype none
module msa_dsp_timer #(
  parameter int CYCLE_WIDTH = 16,
  parameter int NS_WIDTH    = 32
) (
  // Clock and reset.
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  // Timing events.
  input  wire logic                   frameTick,
  input  wire logic                   lineCycleTick,
  // Settings.
  input  wire logic [CYCLE_WIDTH-1:0] lineCycleCount,
  input  wire logic [NS_WIDTH-1:0]    cycleLength,
  // Results.
  output logic                        dspCycleTick,
  output logic                        dspCalcStart
);
  `include "msa_params.svh"

  if (NS_WIDTH != 32 || CYCLE_WIDTH < 1) begin : gChk
    $error("msa_dsp_timer: unsupported widths");
  end

  logic [NS_WIDTH:0]      frameAcc_r, frameAcc_nxt;
  logic [CYCLE_WIDTH-1:0] lineCnt_r, lineCnt_nxt;
  logic                   dspTick_r, dspTick_nxt;
  logic                   calc_r, calc_nxt;
  logic [NS_WIDTH:0]      sum;

  always_comb begin
    sum = frameAcc_r;
    frameAcc_nxt = frameAcc_r;
    dspTick_nxt = 1'b0;
    lineCnt_nxt = lineCnt_r;
    calc_nxt = 1'b0;
    // RULE12: frames counted in 1/65536 units
    if (frameTick) begin
      sum = frameAcc_r + {1'b0, `MSA_FRAME_UNIT};
      if (cycleLength != '0 && sum >= {1'b0, cycleLength}) begin
        frameAcc_nxt = sum - {1'b0, cycleLength};
        dspTick_nxt = 1'b1;
      end else begin
        frameAcc_nxt = sum;
      end
    end
    // RULE11: calculate after counted line cycles
    if (lineCycleTick) begin
      if (lineCycleCount != '0 && lineCnt_r + 1'b1 >= lineCycleCount) begin
        lineCnt_nxt = '0;
        calc_nxt = 1'b1;
      end else begin
        lineCnt_nxt = lineCnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      frameAcc_r <= '0;
      lineCnt_r <= '0;
      dspTick_r <= 1'b0;
      calc_r <= 1'b0;
    end else begin
      frameAcc_r <= frameAcc_nxt;
      lineCnt_r <= lineCnt_nxt;
      dspTick_r <= dspTick_nxt;
      calc_r <= calc_nxt;
    end
  end

  assign dspCycleTick = dspTick_r;
  assign dspCalcStart = calc_r;
endmodule
`default_nettype wire

// file: rtl/msa_config_bank.sv
// Contract
// RULE1: input select picks pair, autozero, temperature
// RULE2: disable bit skips temperature slot conversion
// RULE3: gain is two to the code
// RULE4: host never programs gain above 101
// RULE5: temperature slot resets to 1000,1,010
// RULE6: host leaves temperature slot alone
// RULE7: auxiliary channel RMS computed alongside
// RULE8: bit 6 enables auxiliary processing
// RULE9: bits 2:0 pick aux input
// RULE10: clock kHz register resets 0x1F40
// RULE11: calculations after programmed line cycles
// RULE12: cycle length in frames, 0x10000 each
// RULE13: firmware recomputes cycle length
// RULE14: host may write cycle length
// RULE15: aux reserved bits read zero
`default_nettype none
module msa_config_bank
  import msa_pkg::*;
#(
  parameter int AUX_WIN_LOG2 = 8
) (
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // Host register port.
  input  wire logic [11:0]          regAddr,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  input  wire logic [15:0]          regWdata,
  output logic      [15:0]          regRdata,
  output logic                      regRdataValid,
  // Firmware updates.
  input  wire logic                 fwTempWrite,
  input  wire logic [7:0]           fwTempData,
  input  wire logic                 fwNsWrite,
  input  wire logic [31:0]          fwNsData,
  // Temperature time slot.
  input  wire logic                 tempSlotStrobe,
  output logic      [3:0]           tempMuxSelect,
  output msa_pkg::msa_source_type   tempSource,
  output logic                      tempConvStart,
  output logic      [5:0]           tempGain,
  // Auxiliary channel.
  input  wire logic                 auxSampleValid,
  input  wire logic signed [15:0]   auxSample,
  output logic                      auxEnable,
  output logic      [2:0]           auxInputSelect,
  output logic      [15:0]          auxRms,
  output logic                      auxRmsValid,
  // Timing.
  input  wire logic                 frameTick,
  input  wire logic                 lineCycleTick,
  output logic      [15:0]          clockKhz,
  output logic      [31:0]          dspCycleLength,
  output logic                      dspCycleTick,
  output logic                      dspCalcStart
);
  import msa_pkg::*;
  `include "msa_params.svh"

  localparam int SUM_W = 32 + AUX_WIN_LOG2;

  if (AUX_WIN_LOG2 < 1 || AUX_WIN_LOG2 > 16) begin : gChk
    $error("msa_config_bank: AUX_WIN_LOG2 out of range");
  end

  // Register state.
  logic [7:0]  tempSlot_r, tempSlot_nxt;
  logic [15:0] auxCfg_r, auxCfg_nxt;
  logic [15:0] sysKhz_r, sysKhz_nxt;
  logic [15:0] lineCyc_r, lineCyc_nxt;
  logic [31:0] ns_r, ns_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;

  always_comb begin
    tempSlot_nxt = tempSlot_r;
    auxCfg_nxt = auxCfg_r;
    sysKhz_nxt = sysKhz_r;
    lineCyc_nxt = lineCyc_r;
    ns_nxt = ns_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = regRead;
    // RULE13: firmware cycle length update
    if (fwNsWrite) begin
      ns_nxt = fwNsData;
    end
    if (regWrite) begin
      case (regAddr)
        `MSA_OFS_TEMP_SLOT: begin
          tempSlot_nxt = regWdata[7:0];
        end
        // RULE15: reserved bits held at zero
        `MSA_OFS_AUX_CFG: begin
          auxCfg_nxt = regWdata & `MSA_AUX_WRITE_MASK;
        end
        `MSA_OFS_SYSTEM_CLOCK_KHZ: begin
          sysKhz_nxt = regWdata;
        end
        `MSA_OFS_LINE_CYCLES: begin
          lineCyc_nxt = regWdata;
        end
        // RULE14: host write taken over firmware
        `MSA_OFS_NS_LOW: begin
          ns_nxt = {ns_r[31:16], regWdata};
        end
        `MSA_OFS_NS_HIGH: begin
          ns_nxt = {regWdata, ns_r[15:0]};
        end
        default: begin
        end
      endcase
    end
    // Firmware owns the slot, so its update wins over the host.
    if (fwTempWrite) begin
      tempSlot_nxt = fwTempData;
    end
    if (regRead) begin
      case (regAddr)
        `MSA_OFS_TEMP_SLOT:   rdata_nxt = {8'h00, tempSlot_r};
        `MSA_OFS_AUX_CFG:     rdata_nxt = auxCfg_r;
        `MSA_OFS_SYSTEM_CLOCK_KHZ:     rdata_nxt = sysKhz_r;
        `MSA_OFS_LINE_CYCLES: rdata_nxt = lineCyc_r;
        `MSA_OFS_NS_LOW:      rdata_nxt = ns_r[15:0];
        `MSA_OFS_NS_HIGH:     rdata_nxt = ns_r[31:16];
        default:              rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      // RULE5: temperature slot reset value
      tempSlot_r <= `MSA_TEMP_RESET;
      auxCfg_r <= `MSA_AUX_RESET;
      // RULE10: clock frequency reset value
      sysKhz_r <= `MSA_SYSTEM_CLOCK_KHZ_RESET;
      lineCyc_r <= `MSA_LINE_CYC_RESET;
      ns_r <= `MSA_NS_RESET;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      tempSlot_r <= tempSlot_nxt;
      auxCfg_r <= auxCfg_nxt;
      sysKhz_r <= sysKhz_nxt;
      lineCyc_r <= lineCyc_nxt;
      ns_r <= ns_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Temperature slot decode.
  logic [3:0] muxCode;
  logic [2:0] gainCode;

  assign muxCode  = tempSlot_r[`MSA_TEMP_MUX_HI:`MSA_TEMP_MUX_LO];
  assign gainCode = tempSlot_r[`MSA_TEMP_GAIN_HI:`MSA_TEMP_GAIN_LO];

  always_comb begin
    // RULE1: input select decode
    if (muxCode[3]) begin
      tempSource = MSA_SRC_TEMPERATURE;
    end else if (muxCode == `MSA_MUX_AUTOZERO) begin
      tempSource = MSA_SRC_AUTOZERO;
    end else if (muxCode == `MSA_MUX_LAST_PAIR) begin
      tempSource = MSA_SRC_NEUTRAL;
    end else if (muxCode > `MSA_MUX_V_LAST) begin
      tempSource = MSA_SRC_CURRENT;
    end else begin
      tempSource = MSA_SRC_VOLTAGE;
    end
    // RULE3: gain as power of two
    if (gainCode <= `MSA_GAIN_MAX_CODE) begin
      tempGain = 6'h01 << gainCode;
    end else begin
      // RULE4: reserved codes give no gain
      tempGain = 6'h00;
    end
  end

  assign tempMuxSelect = muxCode;
  // RULE2: skip conversion when disabled
  assign tempConvStart = tempSlotStrobe & ~tempSlot_r[`MSA_TEMP_DIS_BIT];

  // RULE8: enable bit gates aux channel
  assign auxEnable      = auxCfg_r[`MSA_AUX_EN_BIT];
  // RULE9: aux input select field
  assign auxInputSelect = auxCfg_r[`MSA_AUX_SEL_HI:`MSA_AUX_SEL_LO];

  // Auxiliary RMS over a power-of-two window, then a bitwise root.
  msa_rms_state_type      rmsState_r, rmsState_nxt;
  logic [SUM_W-1:0]       sumSq_r, sumSq_nxt;
  logic [AUX_WIN_LOG2-1:0] cnt_r, cnt_nxt;
  logic [31:0]            meanSq_r, meanSq_nxt;
  logic [15:0]            root_r, root_nxt;
  logic [3:0]             bitIdx_r, bitIdx_nxt;
  logic [15:0]            rms_r, rms_nxt;
  logic                   rmsValid_r, rmsValid_nxt;
  logic [15:0]            trial;
  logic [31:0]            square;
  logic [15:0]            magnitude;

  always_comb begin
    rmsState_nxt = rmsState_r;
    sumSq_nxt = sumSq_r;
    cnt_nxt = cnt_r;
    meanSq_nxt = meanSq_r;
    root_nxt = root_r;
    bitIdx_nxt = bitIdx_r;
    rms_nxt = rms_r;
    rmsValid_nxt = 1'b0;
    magnitude = auxSample[15] ? 16'(-auxSample) : 16'(auxSample);
    square = magnitude * magnitude;
    trial = root_r | (16'h0001 << bitIdx_r);
    // RULE7: accumulate and root aux samples
    case (rmsState_r)
      MSA_RMS_COLLECT: begin
        if (auxSampleValid && auxEnable) begin
          sumSq_nxt = sumSq_r + SUM_W'(square);
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == '1) begin
            meanSq_nxt = 32'(sumSq_nxt >> AUX_WIN_LOG2);
            sumSq_nxt = '0;
            root_nxt = 16'h0000;
            bitIdx_nxt = 4'hf;
            rmsState_nxt = MSA_RMS_ROOT;
          end
        end
      end
      MSA_RMS_ROOT: begin
        if (trial * trial <= meanSq_r) begin
          root_nxt = trial;
        end
        bitIdx_nxt = bitIdx_r - 1'b1;
        if (bitIdx_r == 4'h0) begin
          rms_nxt = (trial * trial <= meanSq_r) ? trial : root_r;
          rmsValid_nxt = 1'b1;
          rmsState_nxt = MSA_RMS_COLLECT;
        end
      end
      default: begin
        rmsState_nxt = MSA_RMS_COLLECT;
      end
    endcase
    if (!auxEnable) begin
      sumSq_nxt = '0;
      cnt_nxt = '0;
      rmsState_nxt = MSA_RMS_COLLECT;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rmsState_r <= MSA_RMS_COLLECT;
      sumSq_r <= '0;
      cnt_r <= '0;
      meanSq_r <= 32'h00000000;
      root_r <= 16'h0000;
      bitIdx_r <= 4'h0;
      rms_r <= 16'h0000;
      rmsValid_r <= 1'b0;
    end else begin
      rmsState_r <= rmsState_nxt;
      sumSq_r <= sumSq_nxt;
      cnt_r <= cnt_nxt;
      meanSq_r <= meanSq_nxt;
      root_r <= root_nxt;
      bitIdx_r <= bitIdx_nxt;
      rms_r <= rms_nxt;
      rmsValid_r <= rmsValid_nxt;
    end
  end

  msa_dsp_timer #(
    .CYCLE_WIDTH (16),
    .NS_WIDTH    (32)
  ) uTimer (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .frameTick      (frameTick),
    .lineCycleTick  (lineCycleTick),
    .lineCycleCount (lineCyc_r),
    .cycleLength    (ns_r),
    .dspCycleTick   (dspCycleTick),
    .dspCalcStart   (dspCalcStart)
  );

  assign regRdata       = rdata_r;
  assign regRdataValid  = rvalid_r;
  assign auxRms         = rms_r;
  assign auxRmsValid    = rmsValid_r;
  assign clockKhz       = sysKhz_r;
  assign dspCycleLength = ns_r;
endmodule
`default_nettype wire

// file: sim/msa_config_bank_properties.sv
`default_nettype none
module msa_config_bank_properties
  import msa_pkg::*;
(
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // Register port.
  input wire logic [11:0] regAddr,
  input wire logic        regRead,
  input wire logic [15:0] regRdata,
  // Slot, channel and timing signals.
  input wire logic        tempSlotStrobe,
  input wire logic [3:0]  tempMuxSelect,
  input var  msa_pkg::msa_source_type tempSource,
  input wire logic        tempConvStart,
  input wire logic [5:0]  tempGain,
  input wire logic        auxEnable,
  input wire logic [2:0]  auxInputSelect,
  input wire logic [15:0] clockKhz,
  input wire logic        lineCycleTick,
  input wire logic        dspCalcStart
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(a);
    regRead && regAddr == a;
  endsequence
  chk_src_temp: assert property (tempMuxSelect[3] |->
    tempSource == MSA_SRC_TEMPERATURE) else $error("source not temperature");
  chk_src_zero: assert property (tempMuxSelect == 4'h7 |->
    tempSource == MSA_SRC_AUTOZERO) else $error("source not autozero");
  chk_conv_gate: assert property (tempConvStart |-> tempSlotStrobe)
    else $error("conversion outside slot");
  chk_gain_pow: assert property ($onehot0(tempGain))
    else $error("gain not a power of two");
  chk_reset_vals: assert property (disable iff (1'h0) !reset_n |=>
    clockKhz == 16'h1f40 && tempGain == 6'h4 && tempMuxSelect == 4'h8
    && !auxEnable) else $error("reset values wrong");
  chk_khz_read: assert property (s_rd(12'h012) |=>
    regRdata == $past(clockKhz)) else $error("clock read wrong");
  chk_aux_rsv: assert property (s_rd(12'h010) |=>
    regRdata[15:7] == 9'h0 && regRdata[5:3] == 3'h0)
    else $error("reserved aux bits set");
  chk_aux_en: assert property (s_rd(12'h010) |=>
    regRdata[6] == $past(auxEnable) && regRdata[2:0] == $past(auxInputSelect))
    else $error("aux fields mismatch");
  chk_calc_cause: assert property (dspCalcStart |->
    $past(lineCycleTick)) else $error("calc start without tick");
endmodule
bind msa_config_bank msa_config_bank_properties i_props (.sys_clk, .reset_n,
  .regAddr, .regRead, .regRdata, .tempSlotStrobe, .tempMuxSelect, .tempSource,
  .tempConvStart, .tempGain, .auxEnable, .auxInputSelect, .clockKhz,
  .lineCycleTick, .dspCalcStart);
`default_nettype wire

// file: sim/msa_host_model.sv
`default_nettype none
module msa_host_model (
  // Clock and read return.
  input  wire logic        sys_clk,
  input  wire logic [15:0] regRdata,
  // Register requests.
  output logic      [11:0] regAddr,
  output logic             regWrite,
  output logic             regRead,
  output logic      [15:0] regWdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    regAddr = 12'h000;
    regWrite = 1'h0;
    regRead = 1'h0;
    regWdata = 16'h0000;
  end
  // Idle lines are inverted so a stale address never looks valid.
  // host write
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'h1;
    @(negedge sys_clk);
    regWrite = 1'h0;
    regAddr = ~a;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regRead = 1'h1;
    @(negedge sys_clk);
    regRead = 1'h0;
    regAddr = ~a;
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// file: sim/msa_config_bank_tb.sv
`default_nettype none
module msa_config_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import msa_pkg::*;
  logic        sys_clk, reset_n, regWrite, regRead, regRdataValid;
  logic [11:0] regAddr;
  logic [15:0] regWdata, regRdata, auxRms, clockKhz;
  logic        fwTempWrite, fwNsWrite, tempSlotStrobe, tempConvStart;
  logic [7:0]  fwTempData;
  logic [31:0] fwNsData, dspCycleLength;
  logic [3:0]  tempMuxSelect;
  logic [5:0]  tempGain;
  logic [2:0]  auxInputSelect;
  logic        auxSampleValid, auxEnable, auxRmsValid, frameTick;
  logic        lineCycleTick, dspCycleTick, dspCalcStart;
  logic signed [15:0] auxSample;
  msa_source_type tempSource;
  int          n_errors, tests_run, i;
  logic [11:0] ofs [6] = '{12'h00f, 12'h010, 12'h012, 12'h014, 12'h016,
                           12'h018};
  logic [15:0] rst [6] = '{16'h008a, 16'h0000, 16'h1f40, 16'h0010, 16'h0000,
                           16'h0001};

  msa_config_bank #(.AUX_WIN_LOG2(1)) i_dut (.*);
  msa_host_model i_host (.sys_clk, .regRdata, .regAddr, .regWrite, .regRead,
    .regWdata);

  initial sys_clk = 1'h0;
  always #2 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_host.rd(a, d);
    chk(32'(d), 32'(exp));
    // The read strobe must be answered by a valid pulse one cycle later.
    chk(32'(regRdataValid), 32'h1);
  endtask
  task automatic strobe(input logic exp);
    @(negedge sys_clk);
    tempSlotStrobe = 1'h1;
    #1 chk(32'(tempConvStart), 32'(exp));
    @(negedge sys_clk);
    tempSlotStrobe = 1'h0;
  endtask
  function automatic msa_source_type srcOf(input logic [3:0] m);
    if (m[3]) return MSA_SRC_TEMPERATURE;
    if (m == 4'h7) return MSA_SRC_AUTOZERO;
    if (m == 4'h6) return MSA_SRC_NEUTRAL;
    return (m < 4'h3) ? MSA_SRC_VOLTAGE : MSA_SRC_CURRENT;
  endfunction
  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    close_out;
  end

  initial begin
    reset_n = 1'h0;
    {fwTempWrite, fwNsWrite, tempSlotStrobe, auxSampleValid} = 4'h0;
    {frameTick, lineCycleTick} = 2'h0;
    fwTempData = 8'h00;
    fwNsData = 32'h0;
    auxSample = 16'sh0;
    repeat (20) @(negedge sys_clk);
    reset_n = 1'h1;
    chk(32'(tempGain), 32'h4);
    chk(32'(tempConvStart), 32'h0);
    for (i = 0; i < 6; i++) rchk(ofs[i], rst[i]);
    i_host.wr(12'h020, 16'hbeef);
    rchk(12'h020, 16'h0000);
    i_host.wr(12'h012, 16'h2ee0);
    chk(32'(clockKhz), 32'h2ee0);
    rchk(12'h012, 16'h2ee0);
    i_host.wr(12'h010, 16'hffff);
    rchk(12'h010, 16'h0047);
    chk(32'(auxEnable), 32'h1);
    i_host.wr(12'h010, 16'h0041);
    chk(32'(auxInputSelect), 32'h1);
    // Host slot writes stay within the legal gain codes.
    for (i = 0; i < 6; i++) begin
      i_host.wr(12'h00f, {8'h00, 4'h8, 1'h1, 3'(i)});
      chk(32'(tempGain), 32'h1 << i);
    end
    for (i = 0; i < 9; i++) begin
      i_host.wr(12'h00f, {8'h00, 4'(i), 4'h0});
      chk(32'(tempSource), 32'(srcOf(4'(i))));
    end
    strobe(1'h1);
    i_host.wr(12'h00f, 16'h0088);
    strobe(1'h0);
    @(negedge sys_clk);
    fwTempWrite = 1'h1;
    fwTempData = 8'h70;
    fwNsWrite = 1'h1;
    fwNsData = 32'h00030000;
    @(negedge sys_clk);
    {fwTempWrite, fwNsWrite} = 2'h0;
    fwTempData = 8'h8f;
    fwNsData = 32'hfffcffff;
    rchk(12'h00f, 16'h0070);
    chk(32'(tempSource), 32'(MSA_SRC_AUTOZERO));
    chk(dspCycleLength, 32'h00030000);
    i_host.wr(12'h016, 16'h0000);
    i_host.wr(12'h018, 16'h0002);
    chk(dspCycleLength, 32'h00020000);
    for (i = 1; i < 3; i++) begin
      @(negedge sys_clk) frameTick = 1'h1;
      @(negedge sys_clk) frameTick = 1'h0;
      chk(32'(dspCycleTick), 32'(i == 2));
    end
    i_host.wr(12'h014, 16'h0003);
    for (i = 1; i < 4; i++) begin
      @(negedge sys_clk) lineCycleTick = 1'h1;
      @(negedge sys_clk) lineCycleTick = 1'h0;
      chk(32'(dspCalcStart), 32'(i == 3));
    end
    @(negedge sys_clk);
    auxSampleValid = 1'h1;
    auxSample = 16'sh0003;
    @(negedge sys_clk) auxSample = -16'sh0003;
    @(negedge sys_clk) auxSampleValid = 1'h0;
    auxSample = 16'sh5a5a;
    for (i = 0; i < 30 && auxRmsValid !== 1'h1; i++) @(negedge sys_clk);
    chk(32'(auxRmsValid), 32'h1);
    chk(32'(auxRms), 32'h3);
    close_out;
  end
endmodule
`default_nettype wire
